//--- hw/tcb_block.sv
// Purpose: timer block interrupt masks, software sync, clock routing, id registers
// Assumes: register port strobes are one cycle wide and never overlap
// Notes: channel engines live outside; they feed events in and take clocks out
`timescale 1ns/1ps
module tcb_block
	import tcb_pkg::*;
#(
	parameter logic UPDOWN_PRESENT = 1'b0,
	parameter logic BRIDGE_PB_HSB = 1'b0,
	// arbitrary value
	parameter logic [11:0] MODULE_VERSION = 12'h100,
	// arbitrary value
	parameter logic [3:0] MODULE_VARIANT = 4'h0
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [TCB_EVT_W-1:0] chan0_event,
	input wire logic [TCB_EVT_W-1:0] chan1_event,
	input wire logic [TCB_EVT_W-1:0] chan2_event,
	input wire logic ext_clock_pin_zero,
	input wire logic ext_clock_pin_one,
	input wire logic ext_clock_pin_two,
	input wire logic chan0_io_a,
	input wire logic chan1_io_a,
	input wire logic chan2_io_a,
	input wire logic internal_slow_clock,
	input wire logic [2:0] chan0_clk_sel,
	input wire logic [2:0] chan1_clk_sel,
	input wire logic [2:0] chan2_clk_sel,
	output logic external_clock_input_zero,
	output logic external_clock_input_one,
	output logic external_clock_input_two,
	output logic [4:0] timer_clock,
	output logic chan0_clock,
	output logic chan1_clock,
	output logic chan2_clock,
	output logic sync_trigger,
	output logic timer_irq
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function automatic logic [7:0] chan_ofs(input int n, input logic [7:0] ofs);
	chan_ofs = ofs + 8'(n) * TCB_CHAN_STRIDE;
endfunction : chan_ofs

function automatic logic ext_route(input logic [1:0] sel, input logic pin,
	input logic io_lo, input logic io_hi);
	case (sel)
		TCB_XSEL_PIN: ext_route = pin;
		TCB_XSEL_IO_LO: ext_route = io_lo;
		TCB_XSEL_IO_HI: ext_route = io_hi;
		default: ext_route = 1'b0;
	endcase
endfunction : ext_route

function automatic logic clk_pick(input logic [2:0] sel, input logic [4:0] tclk,
	input logic [2:0] xc);
	case (sel)
		TCB_CSEL_EXT0: clk_pick = xc[0];
		TCB_CSEL_EXT1: clk_pick = xc[1];
		TCB_CSEL_EXT2: clk_pick = xc[2];
		default: clk_pick = tclk[sel];
	endcase
endfunction : clk_pick

////////////////////////////////////////////////////////////////////////////////
// reset release

logic rst_meta_n;
logic rst_sync_n;

always_ff @(posedge clk_sys or negedge rst_n)
begin
	if (!rst_n)
	begin
		rst_meta_n <= 1'b0;
		rst_sync_n <= 1'b0;
	end
	else
	begin
		rst_meta_n <= 1'b1;
		rst_sync_n <= rst_meta_n;
	end
end

////////////////////////////////////////////////////////////////////////////////
// state update

tcb_state_t st;
tcb_state_t next_st;
logic [TCB_CHANS-1:0][TCB_EVT_W-1:0] evt;
logic [31:0] cap_word;
logic [31:0] rev_word;

assign evt = {chan2_event, chan1_event, chan0_event};

always_comb
begin
	cap_word = 32'h0000_0000;
	cap_word[7:0] = TCB_COUNTER_WIDTH;
	cap_word[TCB_UPDOWN_BIT] = UPDOWN_PRESENT;
	cap_word[TCB_BRIDGE_BIT] = BRIDGE_PB_HSB;
	rev_word = 32'h0000_0000;
	rev_word[11:0] = MODULE_VERSION;
	rev_word[TCB_VARIANT_POS +: 4] = MODULE_VARIANT;
end

always_comb
begin
	next_st = st;
	next_st.sync = 1'b0;
	next_st.rdata = 32'h0000_0000;
	for (int n = 0; n < TCB_CHANS; n++)
	begin
		// write-one set/clear of the mask
		if (reg_wr && reg_addr == chan_ofs(n, TCB_IRQ_ENABLE_OFS))
			next_st.mask[n] = st.mask[n] | reg_wdata[TCB_EVT_W-1:0];
		if (reg_wr && reg_addr == chan_ofs(n, TCB_IRQ_DISABLE_OFS))
			next_st.mask[n] = st.mask[n] & ~reg_wdata[TCB_EVT_W-1:0];
		// pending flags: read clears, a new event wins
		if (reg_rd && reg_addr == chan_ofs(n, TCB_CHAN_STATUS_OFS))
			next_st.pend[n] = TCB_PEND_RST;
		if (reg_wr && reg_addr == chan_ofs(n, TCB_CHAN_STATUS_OFS))
			next_st.pend[n] = st.pend[n] & ~reg_wdata[TCB_EVT_W-1:0];
		next_st.pend[n] = next_st.pend[n] | evt[n];
		if (reg_rd && reg_addr == chan_ofs(n, TCB_CHAN_STATUS_OFS))
			next_st.rdata[TCB_EVT_W-1:0] = st.pend[n];
		if (reg_rd && reg_addr == chan_ofs(n, TCB_IRQ_MASK_OFS))
			next_st.rdata[TCB_EVT_W-1:0] = st.mask[n];
	end
	if (reg_wr && reg_addr == TCB_BLOCK_CONTROL_OFS)
		next_st.sync = reg_wdata[TCB_SYNC_BIT];
	if (reg_wr && reg_addr == TCB_BLOCK_MODE_OFS)
		next_st.mode = reg_wdata[TCB_MODE_W-1:0];
	if (reg_rd)
	begin
		case (reg_addr)
			TCB_BLOCK_MODE_OFS: next_st.rdata[TCB_MODE_W-1:0] = st.mode;
			TCB_CAPABILITY_OFS: next_st.rdata = cap_word;
			TCB_REVISION_OFS: next_st.rdata = rev_word;
			default: ;
		endcase
	end
	// internal clocks: slow clock input, then bus clock prescaler taps
	next_st.pre = st.pre + 7'h01;
	next_st.tclk[0] = internal_slow_clock;
	next_st.tclk[1] = next_st.pre[TCB_DIV2_BIT];
	next_st.tclk[2] = next_st.pre[TCB_DIV8_BIT];
	next_st.tclk[3] = next_st.pre[TCB_DIV32_BIT];
	next_st.tclk[4] = next_st.pre[TCB_DIV128_BIT];
	// external clock routing
	next_st.xc[0] = ext_route(st.mode[TCB_SEL0_POS +: 2], ext_clock_pin_zero,
		chan1_io_a, chan2_io_a);
	next_st.xc[1] = ext_route(st.mode[TCB_SEL1_POS +: 2], ext_clock_pin_one,
		chan0_io_a, chan2_io_a);
	next_st.xc[2] = ext_route(st.mode[TCB_SEL2_POS +: 2], ext_clock_pin_two,
		chan0_io_a, chan1_io_a);
	// each channel picks its own source
	next_st.chclk[0] = clk_pick(chan0_clk_sel, st.tclk, st.xc);
	next_st.chclk[1] = clk_pick(chan1_clk_sel, st.tclk, st.xc);
	next_st.chclk[2] = clk_pick(chan2_clk_sel, st.tclk, st.xc);
	next_st.irq = |(next_st.pend & next_st.mask);
end

always_ff @(posedge clk_sys or negedge rst_sync_n)
begin
	if (!rst_sync_n)
	begin
		st.mask <= {TCB_MASK_RST, TCB_MASK_RST, TCB_MASK_RST};
		st.pend <= {TCB_PEND_RST, TCB_PEND_RST, TCB_PEND_RST};
		st.mode <= TCB_MODE_RST;
		st.pre <= 7'h00;
		st.tclk <= 5'h00;
		st.xc <= 3'h0;
		st.chclk <= 3'h0;
		st.sync <= 1'b0;
		st.irq <= 1'b0;
		st.rdata <= 32'h0000_0000;
	end
	else
	begin
		st <= next_st;
	end
end

assign reg_rdata = st.rdata;
assign external_clock_input_zero = st.xc[0];
assign external_clock_input_one = st.xc[1];
assign external_clock_input_two = st.xc[2];
assign timer_clock = st.tclk;
assign chan0_clock = st.chclk[0];
assign chan1_clock = st.chclk[1];
assign chan2_clock = st.chclk[2];
assign sync_trigger = st.sync;
assign timer_irq = st.irq;

////////////////////////////////////////////////////////////////////////////////
// checks

mask_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_wr && reg_addr == TCB_IRQ_ENABLE_OFS |=> (st.mask[0] & $past(reg_wdata[7:0]))
	== $past(reg_wdata[7:0]))
	else $error("enable write did not set mask");

mask_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_wr && reg_addr == TCB_IRQ_DISABLE_OFS |=> (st.mask[0] & $past(reg_wdata[7:0]))
	== 8'h00)
	else $error("disable write did not clear mask");

mask_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	!reg_wr |=> $stable(st.mask))
	else $error("mask changed without a write");

mask_read_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == TCB_IRQ_MASK_OFS |=> reg_rdata == {24'h0, $past(st.mask[0])})
	else $error("mask read wrong");

sync_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	sync_trigger |-> $past(reg_wr) && $past(reg_addr) == TCB_BLOCK_CONTROL_OFS
	&& $past(reg_wdata[0]))
	else $error("sync without its write");

xc0_route_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[1:0] == TCB_XSEL_NONE && $stable(st.mode) |=> !external_clock_input_zero)
	else $error("input 0 not idle when unrouted");

xc2_route_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[5:4] == TCB_XSEL_IO_HI |=> external_clock_input_two == $past(chan1_io_a))
	else $error("input 2 routing wrong");

cap_read_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == TCB_CAPABILITY_OFS |=> reg_rdata[7:0] == TCB_COUNTER_WIDTH)
	else $error("counter width wrong");

div2_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	timer_clock[1] |=> !timer_clock[1] ##1 timer_clock[1])
	else $error("divide by two clock wrong");

read_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == TCB_CHAN_STATUS_OFS && chan0_event == 8'h00 |=> st.pend[0] == 8'h00)
	else $error("status read did not clear");

irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	!reg_wr && !reg_rd && evt == 24'h000000 |=> $stable(timer_irq))
	else $error("interrupt level moved without a cause");

irq_event_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	!reg_wr && !reg_rd && |(evt & st.mask) |=> timer_irq)
	else $error("unmasked event did not raise interrupt");

mask_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_wr && reg_addr == TCB_IRQ_ENABLE_OFS |=> (st.mask[0] & ~$past(reg_wdata[7:0]))
	== ($past(st.mask[0]) & ~$past(reg_wdata[7:0])))
	else $error("enable write changed a bit written as zero");

mask_set1_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_wr && reg_addr == chan_ofs(1, TCB_IRQ_ENABLE_OFS) |=>
	(st.mask[1] & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
	else $error("enable write did not set mask 1");

mask_clear1_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_wr && reg_addr == chan_ofs(1, TCB_IRQ_DISABLE_OFS) |=>
	(st.mask[1] & $past(reg_wdata[7:0])) == 8'h00)
	else $error("disable write did not clear mask 1");

mask_read1_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == chan_ofs(1, TCB_IRQ_MASK_OFS) |=>
	reg_rdata == {24'h0, $past(st.mask[1])})
	else $error("mask 1 read wrong");

mask_read2_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == chan_ofs(2, TCB_IRQ_MASK_OFS) |=>
	reg_rdata == {24'h0, $past(st.mask[2])})
	else $error("mask 2 read wrong");

read_clear1_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == chan_ofs(1, TCB_CHAN_STATUS_OFS) && chan1_event == 8'h00 |=>
	st.pend[1] == 8'h00)
	else $error("status 1 read did not clear");

status_read_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == TCB_CHAN_STATUS_OFS |=> reg_rdata == {24'h0, $past(st.pend[0])})
	else $error("status read wrong");

event_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	chan0_event != 8'h00 |=> (st.pend[0] & $past(chan0_event)) == $past(chan0_event))
	else $error("event lost against a clear");

xc0_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[1:0] == TCB_XSEL_PIN |=> external_clock_input_zero == $past(ext_clock_pin_zero))
	else $error("input 0 pin routing wrong");

xc0_io1_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[1:0] == TCB_XSEL_IO_LO |=> external_clock_input_zero == $past(chan1_io_a))
	else $error("input 0 channel 1 routing wrong");

xc0_io2_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[1:0] == TCB_XSEL_IO_HI |=> external_clock_input_zero == $past(chan2_io_a))
	else $error("input 0 channel 2 routing wrong");

xc1_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[3:2] == TCB_XSEL_PIN |=> external_clock_input_one == $past(ext_clock_pin_one))
	else $error("input 1 pin routing wrong");

xc1_none_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[3:2] == TCB_XSEL_NONE |=> !external_clock_input_one)
	else $error("input 1 not idle when unrouted");

xc1_io0_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[3:2] == TCB_XSEL_IO_LO |=> external_clock_input_one == $past(chan0_io_a))
	else $error("input 1 channel 0 routing wrong");

xc1_io2_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[3:2] == TCB_XSEL_IO_HI |=> external_clock_input_one == $past(chan2_io_a))
	else $error("input 1 channel 2 routing wrong");

xc2_none_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[5:4] == TCB_XSEL_NONE |=> !external_clock_input_two)
	else $error("input 2 not idle when unrouted");

xc2_io0_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode[5:4] == TCB_XSEL_IO_LO |=> external_clock_input_two == $past(chan0_io_a))
	else $error("input 2 channel 0 routing wrong");

chan0_ext_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	chan0_clk_sel == TCB_CSEL_EXT0 |=> chan0_clock == $past(external_clock_input_zero))
	else $error("channel 0 external source wrong");

chan0_int_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	chan0_clk_sel == 3'h0 |=> chan0_clock == $past(timer_clock[0]))
	else $error("channel 0 internal source wrong");

sync_fire_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_wr && reg_addr == TCB_BLOCK_CONTROL_OFS && reg_wdata[TCB_SYNC_BIT] |=> sync_trigger)
	else $error("sync write gave no pulse");

slow_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	timer_clock[0] == $past(internal_slow_clock))
	else $error("slow clock not passed on");

div8_shape_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	$rose(timer_clock[2]) |=> timer_clock[2][*3] ##1 !timer_clock[2])
	else $error("divide by eight clock wrong");

cap_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == TCB_CAPABILITY_OFS |=> reg_rdata[TCB_UPDOWN_BIT] == UPDOWN_PRESENT
	&& reg_rdata[TCB_BRIDGE_BIT] == BRIDGE_PB_HSB)
	else $error("capability flags wrong");

rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
	!reg_rd |=> reg_rdata == 32'h0000_0000)
	else $error("read data outside its cycle");

sync_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) sync_trigger);
irq_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
	!timer_irq ##1 timer_irq ##[1:20] !timer_irq);
route_c: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mode == 6'h3F);
mask_c: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
	st.mask[1] == 8'hA5);
race_c: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
	reg_rd && reg_addr == TCB_CHAN_STATUS_OFS && chan0_event != 8'h00);

endmodule : tcb_block

//--- hw/tcb_pkg.sv
// Purpose: constants for the timer block control, interrupt mask and clock select logic
// Assumes: 8-bit byte address, 32-bit register data, three channels
// Notes: offsets are byte addresses of aligned words
package tcb_pkg;
	localparam int TCB_CHANS = 3;
	localparam int TCB_EVT_W = 8;
	localparam int TCB_MODE_W = 6;
	localparam int TCB_PRE_W = 7;
	// per-channel offsets, channel n adds n times the stride
	localparam logic [7:0] TCB_CHAN_STRIDE = 8'h40;
	localparam logic [7:0] TCB_CHAN_STATUS_OFS = 8'h20;
	localparam logic [7:0] TCB_IRQ_ENABLE_OFS = 8'h24;
	localparam logic [7:0] TCB_IRQ_DISABLE_OFS = 8'h28;
	localparam logic [7:0] TCB_IRQ_MASK_OFS = 8'h2C;
	// block-wide offsets
	localparam logic [7:0] TCB_BLOCK_CONTROL_OFS = 8'hC0;
	localparam logic [7:0] TCB_BLOCK_MODE_OFS = 8'hC4;
	localparam logic [7:0] TCB_CAPABILITY_OFS = 8'hF8;
	localparam logic [7:0] TCB_REVISION_OFS = 8'hFC;
	// field positions
	localparam int TCB_SYNC_BIT = 0;
	localparam int TCB_SEL0_POS = 0;
	localparam int TCB_SEL1_POS = 2;
	localparam int TCB_SEL2_POS = 4;
	localparam int TCB_UPDOWN_BIT = 8;
	localparam int TCB_BRIDGE_BIT = 9;
	localparam int TCB_VARIANT_POS = 16;
	localparam int TCB_DIV2_BIT = 0;
	localparam int TCB_DIV8_BIT = 2;
	localparam int TCB_DIV32_BIT = 4;
	localparam int TCB_DIV128_BIT = 6;
	// reset values and constants
	localparam logic [TCB_EVT_W-1:0] TCB_MASK_RST = 8'h00;
	localparam logic [TCB_EVT_W-1:0] TCB_PEND_RST = 8'h00;
	localparam logic [TCB_MODE_W-1:0] TCB_MODE_RST = 6'h00;
	localparam logic [7:0] TCB_COUNTER_WIDTH = 8'h10;
	// external clock selector codes
	localparam logic [1:0] TCB_XSEL_PIN = 2'h0;
	localparam logic [1:0] TCB_XSEL_NONE = 2'h1;
	localparam logic [1:0] TCB_XSEL_IO_LO = 2'h2;
	localparam logic [1:0] TCB_XSEL_IO_HI = 2'h3;
	// channel clock source codes: 0..4 internal, 5..7 external inputs
	localparam logic [2:0] TCB_CSEL_EXT0 = 3'h5;
	localparam logic [2:0] TCB_CSEL_EXT1 = 3'h6;
	localparam logic [2:0] TCB_CSEL_EXT2 = 3'h7;
	typedef struct packed {
		logic [TCB_CHANS-1:0][TCB_EVT_W-1:0] mask;
		logic [TCB_CHANS-1:0][TCB_EVT_W-1:0] pend;
		logic [TCB_MODE_W-1:0] mode;
		logic [TCB_PRE_W-1:0] pre;
		logic [4:0] tclk;
		logic [2:0] xc;
		logic [TCB_CHANS-1:0] chclk;
		logic sync;
		logic irq;
		logic [31:0] rdata;
	} tcb_state_t;
endpackage : tcb_pkg

//--- tb/tcb_block_tb.sv
// Purpose: self-checking bench for the timer block control, masks and clock routing
// Assumes: default parameters, 200 MHz clock, strobes driven on the rising edge
// Notes: each scenario is a task that drives and judges on its own
`timescale 1ns/1ps
module tb;
	import tcb_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] chan0_event = 8'h00, chan1_event = 8'h00, chan2_event = 8'h00;
	logic ext_clock_pin_zero = 1'b0, ext_clock_pin_one = 1'b0, ext_clock_pin_two = 1'b0;
	logic chan0_io_a = 1'b0, chan1_io_a = 1'b0, chan2_io_a = 1'b0;
	logic internal_slow_clock = 1'b0;
	logic [2:0] chan0_clk_sel = 3'h5, chan1_clk_sel = 3'h6, chan2_clk_sel = 3'h7;
	logic external_clock_input_zero, external_clock_input_one, external_clock_input_two;
	logic [4:0] timer_clock;
	logic chan0_clock, chan1_clock, chan2_clock, sync_trigger, timer_irq;
	int err_total = 0;
	int n_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	tcb_block tcb_block_inst (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .chan0_event, .chan1_event, .chan2_event, .ext_clock_pin_zero,
		.ext_clock_pin_one, .ext_clock_pin_two, .chan0_io_a, .chan1_io_a, .chan2_io_a,
		.internal_slow_clock, .chan0_clk_sel, .chan1_clk_sel, .chan2_clk_sel,
		.external_clock_input_zero, .external_clock_input_one, .external_clock_input_two,
		.timer_clock, .chan0_clock, .chan1_clock, .chan2_clock, .sync_trigger, .timer_irq);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask : rd
	function automatic logic [2:0] xsel(input logic [1:0] s, input logic [5:0] v);
		logic [3:0] a0, a1, a2;
		a0 = {v[5], v[4], 1'b0, v[0]};
		a1 = {v[5], v[3], 1'b0, v[1]};
		a2 = {v[4], v[3], 1'b0, v[2]};
		return {a2[s], a1[s], a0[s]};
	endfunction : xsel
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(8'h2C, 32'h00000000, "mask0 reset");
		rd(8'hAC, 32'h00000000, "mask2 reset");
		rd(8'hC4, 32'h00000000, "mode reset");
		rd(8'hC0, 32'h00000000, "control reads zero");
		rd(8'h30, 32'h00000000, "unmapped read");
		$display("test reset done");
	endtask : t_reset
	task automatic t_mask();
		wr(8'h64, 32'h000000A5);
		rd(8'h6C, 32'h000000A5, "mask1 set");
		wr(8'h64, 32'h00000000);
		rd(8'h6C, 32'h000000A5, "mask1 zero write");
		wr(8'h68, 32'h00000021);
		rd(8'h6C, 32'h00000084, "mask1 cleared");
		rd(8'h2C, 32'h00000000, "mask0 untouched");
		wr(8'h68, 32'h000000FF);
		rd(8'h6C, 32'h00000000, "mask1 all off");
		$display("test mask done");
	endtask : t_mask
	task automatic t_irq();
		@(posedge clk_sys);
		chan2_event <= 8'h01;
		@(posedge clk_sys);
		chan2_event <= 8'h00;
		cyc(3);
		chk("irq masked", 1'b0, timer_irq);
		wr(8'hA4, 32'h00000001);
		cyc(2);
		chk("irq on", 1'b1, timer_irq);
		wr(8'hA8, 32'h00000001);
		cyc(2);
		chk("irq masked again", 1'b0, timer_irq);
		wr(8'hA4, 32'h00000001);
		cyc(2);
		chk("irq back", 1'b1, timer_irq);
		rd(8'hA0, 32'h00000001, "status2");
		cyc(2);
		chk("irq after read", 1'b0, timer_irq);
		rd(8'hA0, 32'h00000000, "status2 cleared");
		wr(8'h24, 32'h00000080);
		@(posedge clk_sys);
		chan0_event <= 8'h80;
		chan1_event <= 8'h80;
		@(posedge clk_sys);
		chan0_event <= 8'h00;
		chan1_event <= 8'h00;
		cyc(2);
		chk("irq chan0", 1'b1, timer_irq);
		rd(8'h20, 32'h00000080, "status0");
		cyc(2);
		chk("irq chan0 off", 1'b0, timer_irq);
		rd(8'h60, 32'h00000080, "status1 held");
		@(posedge clk_sys);
		chan1_event <= 8'h03;
		@(posedge clk_sys);
		chan1_event <= 8'h00;
		wr(8'h60, 32'h00000001);
		rd(8'h60, 32'h00000002, "status1 write clear");
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= 8'h20;
		chan0_event <= 8'h04;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		chan0_event <= 8'h00;
		#1;
		chk("read beside event", 32'h00000000, reg_rdata);
		rd(8'h20, 32'h00000004, "event beats read clear");
		$display("test irq done");
	endtask : t_irq
	task automatic t_sync();
		wr(8'hC0, 32'h00000000);
		#1;
		chk("sync idle", 1'b0, sync_trigger);
		wr(8'hC0, 32'h00000001);
		#1;
		chk("sync pulse", 1'b1, sync_trigger);
		cyc(1);
		chk("sync ends", 1'b0, sync_trigger);
		$display("test sync done");
	endtask : t_sync
	task automatic t_xsel();
		logic [2:0] e;
		for (int s = 0; s < 4; s++)
		begin
			wr(8'hC4, {26'h0, s[1:0], s[1:0], s[1:0]});
			rd(8'hC4, {26'h0, s[1:0], s[1:0], s[1:0]}, "mode readback");
			for (int b = 0; b < 7; b++)
			begin
				@(posedge clk_sys);
				{chan2_io_a, chan1_io_a, chan0_io_a, ext_clock_pin_two, ext_clock_pin_one,
					ext_clock_pin_zero} <= 6'h01 << b;
				cyc(4);
				e = xsel(s[1:0], 6'h01 << b);
				chk("input0", e[0], external_clock_input_zero);
				chk("input1", e[1], external_clock_input_one);
				chk("input2", e[2], external_clock_input_two);
				chk("chan clocks", e, {chan2_clock, chan1_clock, chan0_clock});
			end
		end
		$display("test xsel done");
	endtask : t_xsel
	task automatic t_ids();
		rd(8'hF8, 32'h00000010, "capability");
		rd(8'hFC, 32'h00000100, "revision");
		$display("test ids done");
	endtask : t_ids
	task automatic t_clk();
		int cnt[5];
		logic [4:0] last;
		@(posedge clk_sys);
		internal_slow_clock <= 1'b1;
		chan0_clk_sel <= 3'h0;
		chan1_clk_sel <= 3'h4;
		cyc(3);
		chk("slow clock", 1'b1, timer_clock[0]);
		chk("chan0 on slow", 1'b1, chan0_clock);
		last = timer_clock;
		for (int i = 0; i < 256; i++)
		begin
			cyc(1);
			chk("chan1 on div128", last[4], chan1_clock);
			for (int k = 0; k < 5; k++)
				cnt[k] += int'(timer_clock[k] != last[k]);
			last = timer_clock;
		end
		chk("div2 toggles", 32'd256, cnt[1]);
		chk("div8 toggles", 32'd64, cnt[2]);
		chk("div32 toggles", 32'd16, cnt[3]);
		chk("div128 toggles", 32'd4, cnt[4]);
		$display("test clk done");
	endtask : t_clk
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_mask();
		t_irq();
		t_sync();
		t_xsel();
		t_ids();
		t_clk();
		test_done();
	end
	initial
	begin
		#100000;
		err_total++;
		test_done();
	end
endmodule : tb
